// File: hdl/ess_sequencer.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ess_sequencer #(
	parameter int TICK_CYCLES = ess_pkg::TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic key_start_i,
	input wire logic key_stop_i,
	input wire logic key_any_i,
	input wire logic auto_start_cond_i,
	input wire logic auto_stop_cond_i,
	input wire logic engine_not_ready_i,
	input wire logic safe_to_start_i,
	input wire logic fault_i,
	input wire logic link_ok_i,
	input wire logic engine_started_i,
	input wire logic above_cutout_i,
	input wire logic zero_freq_i,
	output logic prestart_o,
	output logic ecu_enable_o,
	output logic sender_enable_o,
	output logic alarm_mask_o,
	output logic crank_o,
	output logic stop_solenoid_o,
	output logic backlight_en_o,
	output logic heater_en_o,
	output logic can_en_o,
	output logic speed_cmd_valid_o,
	output logic [15:0] speed_cmd_o,
	output logic auto_mode_o,
	output logic [4:0] state_o
);

	typedef struct packed {
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [4:0] ctrl;
		logic [15:0] warm_spd;
		logic [15:0] cool_spd;
		logic [15:0] min_spd;
		logic [15:0] run_spd;
		logic [3:0] tries;
		logic [ess_pkg::NUM_T*24-1:0] dur;
		ess_pkg::ess_state_t st;
		logic [5:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
		logic [26:0] div;
		logic tick;
		logic [3:0] crank_cnt;
		logic [2:0] ecu_sec;
		logic [7:0] ecu_left;
		logic pre_hold;
		logic skip_cool;
		logic [1:0] stop_held;
		logic [2:0] k_start;
		logic [2:0] k_stop;
		logic [2:0] k_any;
		logic start_prev;
		logic stop_prev;
		logic prestart;
		logic ecu;
		logic sender;
		logic mask;
		logic crank;
		logic sol;
		logic lowpwr;
		logic spd_v;
		logic [15:0] spd;
	} ess_regs_t;

	ess_regs_t q_reg, q_next;

	////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] dur_of(input ess_regs_t r, input int i);
		dur_of = r.dur[i*24 +: 24];
	endfunction : dur_of

	function automatic logic is_zero(input logic [23:0] d);
		is_zero = (d == 24'h000000);
	endfunction : is_zero

	function automatic logic [15:0] upd16(input logic [15:0] o,
		input logic [31:0] d, input logic [3:0] s);
		upd16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction : upd16

	////////////////////////////////////////////////////////////////////
	always_comb begin
		logic auto_m, start_ev, stop_ev, start_lvl, stop_lvl, expired;
		logic do_wr, timed, stepped;
		logic [7:0] a;
		int idx;
		ess_pkg::ess_state_t nx;
		a = 8'h00;
		idx = 0;
		nx = q_reg.st;
		do_wr = 1'b0;
		expired = 1'b0;
		timed = 1'b0;
		stepped = 1'b0;
		q_next = q_reg;
		auto_m = q_reg.ctrl[ess_pkg::C_AUTO];
		q_next.tick = 1'b0;
		q_next.k_start = {q_reg.k_start[1:0], key_start_i};
		q_next.k_stop = {q_reg.k_stop[1:0], key_stop_i};
		q_next.k_any = {q_reg.k_any[1:0], key_any_i};
		start_lvl = q_reg.k_start[1] & q_reg.k_start[2];
		stop_lvl = q_reg.k_stop[1] & q_reg.k_stop[2];
		q_next.start_prev = start_lvl;
		q_next.stop_prev = stop_lvl;
		start_ev = start_lvl & ~q_reg.start_prev;
		stop_ev = stop_lvl & ~q_reg.stop_prev;

		// Second tick from the system clock.
		if (q_reg.div == 27'(TICK_CYCLES - 1)) begin
			q_next.div = '0;
			q_next.tick = 1'b1;
		end else begin
			q_next.div = q_reg.div + 27'h0000001;
		end
		expired = (q_reg.hh == 6'h00) && (q_reg.mm == 6'h00)
			&& (q_reg.ss == 6'h00);
		if (q_reg.tick && !expired) begin
			if (q_reg.ss != 6'h00) begin
				q_next.ss = q_reg.ss - 6'h01;
			end else if (q_reg.mm != 6'h00) begin
				q_next.mm = q_reg.mm - 6'h01;
				q_next.ss = 6'h3B;
			end else begin
				q_next.hh = q_reg.hh - 6'h01;
				q_next.mm = 6'h3B;
				q_next.ss = 6'h3B;
			end
		end

		// ECU stabilize timer keeps its own second count.
		if (q_reg.tick && q_reg.ecu_left != 8'h00) begin
			q_next.ecu_left = q_reg.ecu_left - 8'h01;
		end
		if (q_reg.ecu_left == 8'h00 && q_reg.st != ess_pkg::S_STAB) begin
			q_next.ecu = q_reg.st inside {ess_pkg::S_STOPPED,
				ess_pkg::S_WAIT, ess_pkg::S_ASTART} ? q_reg.ecu
				: 1'b1;
		end

		// Register bus: take address and data in either order.
		if (s_axi_awvalid && !q_reg.aw_ok) begin
			q_next.aw_ok = 1'b1;
			q_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q_reg.w_ok) begin
			q_next.w_ok = 1'b1;
			q_next.wdata = s_axi_wdata;
			q_next.wstrb = s_axi_wstrb;
		end
		do_wr = q_reg.aw_ok && q_reg.w_ok && !q_reg.bvalid;
		if (do_wr) begin
			a = q_reg.awaddr;
			q_next.aw_ok = 1'b0;
			q_next.w_ok = 1'b0;
			q_next.bvalid = 1'b1;
			q_next.bresp = 2'h0;
			if (a == ess_pkg::A_CTRL) begin
				if (q_reg.wstrb[0]) begin
					q_next.ctrl = q_reg.wdata[4:0];
				end
			end else if (a == ess_pkg::A_SPEED) begin
				q_next.warm_spd = upd16(q_reg.warm_spd, q_reg.wdata,
					q_reg.wstrb);
				q_next.cool_spd = upd16(q_reg.cool_spd,
					{16'h0000, q_reg.wdata[31:16]}, {2'h0, q_reg.wstrb[3:2]});
			end else if (a == ess_pkg::A_RUNCMD) begin
				q_next.min_spd = upd16(q_reg.min_spd, q_reg.wdata,
					q_reg.wstrb);
				q_next.run_spd = upd16(q_reg.run_spd,
					{16'h0000, q_reg.wdata[31:16]}, {2'h0, q_reg.wstrb[3:2]});
			end else if (a >= ess_pkg::A_DUR0 && a <= ess_pkg::A_LAST
				&& a[1:0] == 2'h0) begin
				idx = int'(a - ess_pkg::A_DUR0) >> 2;
				if (&q_reg.wstrb[2:0]) begin
					q_next.dur[idx*24 +: 24] = q_reg.wdata[23:0];
				end
				if (idx == ess_pkg::T_CRANK && q_reg.wstrb[3]) begin
					q_next.tries = q_reg.wdata[27:24];
				end
			end else begin
				q_next.bresp = 2'h2;
			end
		end
		if (q_reg.bvalid && s_axi_bready) begin
			q_next.bvalid = 1'b0;
		end
		if (s_axi_arvalid && !q_reg.rvalid) begin
			a = s_axi_araddr;
			q_next.rvalid = 1'b1;
			q_next.rresp = 2'h0;
			q_next.rdata = '0;
			if (a == ess_pkg::A_CTRL) begin
				q_next.rdata = {27'h0000000, q_reg.ctrl};
			end else if (a == ess_pkg::A_STATUS) begin
				q_next.rdata = {5'h00, q_reg.crank_cnt, q_reg.hh, q_reg.mm,
					q_reg.ss, q_reg.st};
			end else if (a == ess_pkg::A_SPEED) begin
				q_next.rdata = {q_reg.cool_spd, q_reg.warm_spd};
			end else if (a == ess_pkg::A_RUNCMD) begin
				q_next.rdata = {q_reg.run_spd, q_reg.min_spd};
			end else if (a >= ess_pkg::A_DUR0 && a <= ess_pkg::A_LAST
				&& a[1:0] == 2'h0) begin
				idx = int'(a - ess_pkg::A_DUR0) >> 2;
				q_next.rdata = {8'h00, dur_of(q_reg, idx)};
				if (idx == ess_pkg::T_CRANK) begin
					q_next.rdata[27:24] = q_reg.tries;
				end
			end else begin
				q_next.rresp = 2'h2;
			end
		end
		if (q_reg.rvalid && s_axi_rready) begin
			q_next.rvalid = 1'b0;
		end

		// Start and stop commands from key or register pulse.
		start_ev = start_ev | (do_wr && q_reg.awaddr == ess_pkg::A_CTRL
			&& q_reg.wdata[ess_pkg::C_START]);
		stop_ev = stop_ev | (do_wr && q_reg.awaddr == ess_pkg::A_CTRL
			&& q_reg.wdata[ess_pkg::C_STOP]);
		q_next.ctrl[ess_pkg::C_START] = 1'b0;
		q_next.ctrl[ess_pkg::C_STOP] = 1'b0;
		if (do_wr && q_reg.awaddr == ess_pkg::A_CTRL) begin
			q_next.ctrl[ess_pkg::C_AUTO] = q_reg.wdata[ess_pkg::C_AUTO];
		end

		// Held stop: two seconds of an asserted key skip cooldown.
		if (!stop_lvl) begin
			q_next.stop_held = 2'h0;
		end else if (q_reg.tick && q_reg.stop_held != 2'(ess_pkg::HOLD_S)) begin
			q_next.stop_held = q_reg.stop_held + 2'h1;
		end
		if (auto_m && (q_reg.stop_held == 2'(ess_pkg::HOLD_S)
			|| (stop_ev && q_reg.st inside {ess_pkg::S_ASTOP,
			ess_pkg::S_COOL}))) begin
			q_next.skip_cool = 1'b1;
		end

		// Sequencer: fixed order, zero-duration PRE1, WARM, COOL and ASTART skipped in auto mode.
		nx = q_reg.st;
		timed = 1'b0;
		stepped = 1'b0;
		case (q_reg.st)
			ess_pkg::S_STAB: begin
				if (expired || q_reg.ctrl[ess_pkg::C_MECH]) begin
					nx = ess_pkg::S_STOPPED;
				end
			end
			ess_pkg::S_STOPPED, ess_pkg::S_STANDBY: begin
				if (engine_not_ready_i && (start_ev || auto_start_cond_i)) begin
					nx = ess_pkg::S_WAIT;
				end else if (start_ev && !auto_m) begin
					nx = ess_pkg::S_PRE1;
				end else if (auto_m && (auto_start_cond_i || start_ev)) begin
					nx = ess_pkg::S_ASTART;
				end else if (q_reg.st == ess_pkg::S_STOPPED && expired
					&& !is_zero(dur_of(q_reg, ess_pkg::T_STOPPED))) begin
					nx = ess_pkg::S_STANDBY;
				end else if (q_reg.st == ess_pkg::S_STANDBY
					&& q_reg.k_any[1] && q_reg.k_any[2]) begin
					nx = ess_pkg::S_STOPPED;
				end
			end
			ess_pkg::S_WAIT: begin
				if (!engine_not_ready_i) begin
					nx = auto_m ? ess_pkg::S_ASTART : ess_pkg::S_PRE1;
				end
			end
			ess_pkg::S_ASTART: begin
				if (!auto_m) begin
					nx = ess_pkg::S_STOPPED;
				end else if (!auto_start_cond_i) begin
					timed = 1'b1;
				end else if (expired) begin
					nx = ess_pkg::S_PRE1;
				end
			end
			ess_pkg::S_PRE1: if (expired) nx = ess_pkg::S_SAFE;
			ess_pkg::S_SAFE: if (safe_to_start_i) nx = ess_pkg::S_PRE2;
			ess_pkg::S_PRE2: begin
				if (fault_i || !link_ok_i) begin
					nx = ess_pkg::S_SPIN;
				end else if (expired) begin
					nx = ess_pkg::S_CRANK;
				end
			end
			ess_pkg::S_CRANK: begin
				if (engine_started_i) begin
					nx = ess_pkg::S_FALSE;
				end else if (expired) begin
					nx = (q_reg.crank_cnt + 4'h1 >= q_reg.tries)
						? ess_pkg::S_SPIN : ess_pkg::S_REST;
				end
			end
			ess_pkg::S_REST: if (expired) nx = ess_pkg::S_CRANK;
			ess_pkg::S_FALSE: begin
				nx = above_cutout_i ? (auto_m ? ess_pkg::S_WARM
					: ess_pkg::S_RUN) : ess_pkg::S_REST;
			end
			ess_pkg::S_WARM: if (expired || !auto_m) nx = ess_pkg::S_RUN;
			ess_pkg::S_RUN: begin
				if (stop_ev) begin
					nx = (auto_m && !q_reg.skip_cool) ? ess_pkg::S_COOL
						: ess_pkg::S_SOLENOID;
				end else if (auto_m && auto_stop_cond_i) begin
					nx = ess_pkg::S_ASTOP;
				end
			end
			ess_pkg::S_ASTOP: begin
				if (!auto_stop_cond_i || !auto_m) begin
					nx = ess_pkg::S_RUN;
				end else if (expired || stop_ev) begin
					nx = q_reg.skip_cool || stop_ev ? ess_pkg::S_SOLENOID
						: ess_pkg::S_COOL;
				end
			end
			ess_pkg::S_COOL: begin
				if (expired || q_reg.skip_cool || !auto_m) begin
					nx = ess_pkg::S_SOLENOID;
				end
			end
			ess_pkg::S_SOLENOID: if (expired) nx = ess_pkg::S_SPIN;
			ess_pkg::S_SPIN: begin
				if (expired && zero_freq_i) nx = ess_pkg::S_STOPPED;
			end
			default: nx = ess_pkg::S_STOPPED;
		endcase

		// Skip zero-duration PRE1, WARM, COOL and ASTART states in auto mode only.
		if (auto_m) begin
			if (nx == ess_pkg::S_PRE1 && is_zero(dur_of(q_reg, ess_pkg::T_PRE1)))
				nx = ess_pkg::S_SAFE;
			if (nx == ess_pkg::S_WARM && is_zero(dur_of(q_reg, ess_pkg::T_WARM)))
				nx = ess_pkg::S_RUN;
			if (nx == ess_pkg::S_COOL && is_zero(dur_of(q_reg, ess_pkg::T_COOL)))
				nx = ess_pkg::S_SOLENOID;
			if (nx == ess_pkg::S_ASTART
				&& is_zero(dur_of(q_reg, ess_pkg::T_ASTART)))
				nx = ess_pkg::S_PRE1;
		end

		stepped = (nx != q_reg.st);
		if (stepped || timed) begin
			idx = ess_pkg::T_STOPPED;
			case (nx)
				ess_pkg::S_STAB: idx = ess_pkg::T_STAB;
				ess_pkg::S_STANDBY: idx = ess_pkg::T_STANDBY;
				ess_pkg::S_ASTART: idx = ess_pkg::T_ASTART;
				ess_pkg::S_PRE1: idx = ess_pkg::T_PRE1;
				ess_pkg::S_PRE2: idx = ess_pkg::T_PRE2;
				ess_pkg::S_CRANK: idx = ess_pkg::T_CRANK;
				ess_pkg::S_REST: idx = ess_pkg::T_REST;
				ess_pkg::S_WARM: idx = ess_pkg::T_WARM;
				ess_pkg::S_ASTOP: idx = ess_pkg::T_ASTOP;
				ess_pkg::S_COOL: idx = ess_pkg::T_COOL;
				ess_pkg::S_SOLENOID: idx = ess_pkg::T_SOLENOID;
				ess_pkg::S_SPIN: idx = ess_pkg::T_SPIN;
				default: idx = ess_pkg::T_STOPPED;
			endcase
			{q_next.hh, q_next.mm, q_next.ss} = 18'(dur_of(q_reg, idx));
			q_next.div = '0;
		end
		q_next.st = nx;
		if (stepped && nx == ess_pkg::S_CRANK) begin
			q_next.crank_cnt = q_reg.crank_cnt + 4'h1;
		end
		if (stepped && nx == ess_pkg::S_PRE1) begin
			q_next.crank_cnt = 4'h0;
		end
		if (stepped && q_reg.st == ess_pkg::S_SPIN) begin
			q_next.skip_cool = 1'b0;
			q_next.ctrl[ess_pkg::C_AUTO] = 1'b0;
		end
		// ECU timer restarts at spindown and on leaving standby.
		if (stepped && (nx == ess_pkg::S_SPIN || q_reg.st == ess_pkg::S_STANDBY)) begin
			q_next.ecu_left = 8'(dur_of(q_reg, ess_pkg::T_ECU));
			q_next.ecu = 1'b1;
		end
		if (stepped && nx inside {ess_pkg::S_STANDBY, ess_pkg::S_SOLENOID}) begin
			q_next.ecu = 1'b0;
			q_next.ecu_left = 8'h00;
		end

		// Outputs.
		q_next.sender = nx == ess_pkg::S_STAB;
		q_next.mask = nx == ess_pkg::S_STAB;
		if (nx == ess_pkg::S_STAB) q_next.ecu = 1'b1;
		q_next.lowpwr = nx == ess_pkg::S_STANDBY;
		q_next.crank = nx == ess_pkg::S_CRANK;
		q_next.sol = nx == ess_pkg::S_SOLENOID;
		if (stepped && nx == ess_pkg::S_PRE2) begin
			q_next.pre_hold = q_reg.ctrl[ess_pkg::C_CRANKTHRU];
		end
		if (engine_started_i || nx inside {ess_pkg::S_SPIN,
			ess_pkg::S_STOPPED}) begin
			q_next.pre_hold = 1'b0;
		end
		q_next.prestart = (nx == ess_pkg::S_PRE1) || (nx == ess_pkg::S_PRE2)
			|| (q_next.pre_hold && nx inside {ess_pkg::S_CRANK,
			ess_pkg::S_REST});
		q_next.spd_v = 1'b1;
		q_next.spd = q_reg.run_spd;
		if (nx == ess_pkg::S_WARM) begin
			q_next.spd = (q_reg.warm_spd < q_reg.min_spd) ? q_reg.min_spd
				: q_reg.warm_spd;
		end else if (nx == ess_pkg::S_COOL) begin
			q_next.spd = q_reg.cool_spd;
		end else if (!(nx inside {ess_pkg::S_RUN, ess_pkg::S_ASTOP})) begin
			q_next.spd_v = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_reg <= '0;
			q_reg.ctrl <= ess_pkg::CTRL_RST;
			q_reg.tries <= ess_pkg::CRANK_TRIES_RST;
			q_reg.dur <= {ess_pkg::NUM_T{ess_pkg::DUR_RST}};
			q_reg.st <= ess_pkg::S_STAB;
			q_reg.ss <= 6'(ess_pkg::DUR_RST);
			q_reg.ecu <= 1'b1;
			q_reg.ecu_left <= 8'(ess_pkg::DUR_RST);
			q_reg.sender <= 1'b1;
			q_reg.mask <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign s_axi_awready = !q_reg.aw_ok;
	assign s_axi_wready = !q_reg.w_ok;
	assign s_axi_bvalid = q_reg.bvalid;
	assign s_axi_bresp = q_reg.bresp;
	assign s_axi_arready = !q_reg.rvalid;
	assign s_axi_rvalid = q_reg.rvalid;
	assign s_axi_rdata = q_reg.rdata;
	assign s_axi_rresp = q_reg.rresp;
	assign prestart_o = q_reg.prestart;
	assign ecu_enable_o = q_reg.ecu;
	assign sender_enable_o = q_reg.sender;
	assign alarm_mask_o = q_reg.mask;
	assign crank_o = q_reg.crank;
	assign stop_solenoid_o = q_reg.sol;
	// Power savers are off only in standby.
	assign backlight_en_o = !q_reg.lowpwr;
	assign heater_en_o = !q_reg.lowpwr;
	assign can_en_o = !q_reg.lowpwr;
	assign speed_cmd_valid_o = q_reg.spd_v;
	assign speed_cmd_o = q_reg.spd;
	assign auto_mode_o = q_reg.ctrl[ess_pkg::C_AUTO];
	assign state_o = q_reg.st;

endmodule : ess_sequencer
`default_nettype wire

// File: hdl/ess_pkg.sv
package ess_pkg;

	localparam int CLK_HZ = 125000000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	localparam int HOLD_S = 2;

	// Timer index of each timed state and of the ECU timer within the duration table.
	localparam int T_STAB = 0;
	localparam int T_STOPPED = 1;
	localparam int T_STANDBY = 2;
	localparam int T_ASTART = 3;
	localparam int T_PRE1 = 4;
	localparam int T_PRE2 = 5;
	localparam int T_CRANK = 6;
	localparam int T_REST = 7;
	localparam int T_WARM = 8;
	localparam int T_ASTOP = 9;
	localparam int T_COOL = 10;
	localparam int T_SPIN = 11;
	localparam int T_ECU = 12;
	localparam int T_SOLENOID = 13;
	localparam int NUM_T = 14;

	// Register byte addresses; each register one 32-bit word.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_SPEED = 8'h08;
	localparam logic [7:0] A_RUNCMD = 8'h0C;
	localparam logic [7:0] A_DUR0 = 8'h40;
	localparam logic [7:0] A_LAST = 8'h74;

	// Control register fields and register reset values.
	localparam int C_AUTO = 0;
	localparam int C_START = 1;
	localparam int C_STOP = 2;
	localparam int C_MECH = 3;
	localparam int C_CRANKTHRU = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [15:0] SPEED_RST = 16'h0000;
	localparam logic [23:0] DUR_RST = 24'h000005;
	localparam logic [3:0] CRANK_TRIES_RST = 4'h3;

	typedef enum logic [4:0] {
		S_STAB = 5'h00,
		S_STOPPED = 5'h01,
		S_STANDBY = 5'h02,
		S_WAIT = 5'h03,
		S_ASTART = 5'h04,
		S_PRE1 = 5'h05,
		S_SAFE = 5'h06,
		S_PRE2 = 5'h07,
		S_CRANK = 5'h08,
		S_REST = 5'h09,
		S_FALSE = 5'h0A,
		S_WARM = 5'h0B,
		S_RUN = 5'h0C,
		S_ASTOP = 5'h0D,
		S_COOL = 5'h0E,
		S_SOLENOID = 5'h0F,
		S_SPIN = 5'h10
	} ess_state_t;

endpackage : ess_pkg

// File: tb/ess_seq_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ess_seq_checker (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic engine_not_ready_i,
	input wire logic [4:0] state_o,
	input wire logic prestart_o,
	input wire logic ecu_enable_o,
	input wire logic alarm_mask_o,
	input wire logic crank_o,
	input wire logic backlight_en_o,
	input wire logic heater_en_o,
	input wire logic can_en_o,
	input wire logic auto_mode_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Outputs are registered beside the state, so entry cycles are excused.
	property p_stab_ecu;
		state_o == ess_pkg::S_STAB && $past(state_o) == ess_pkg::S_STAB
			|-> ecu_enable_o && alarm_mask_o;
	endproperty
	a_stab_ecu: assert property (p_stab_ecu) else $error("stabilize off");
	property p_pwr_off;
		!(backlight_en_o && heater_en_o && can_en_o) |->
			state_o == ess_pkg::S_STANDBY || $past(state_o) == ess_pkg::S_STANDBY;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power enables");
	property p_wait_hold;
		engine_not_ready_i && state_o == ess_pkg::S_WAIT
			|=> state_o == ess_pkg::S_WAIT;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("left wait");
	property p_pre1_out;
		state_o == ess_pkg::S_PRE1 && $past(state_o) == ess_pkg::S_PRE1
			|-> prestart_o;
	endproperty
	a_pre1_out: assert property (p_pre1_out) else $error("prestart off");
	property p_crank_out;
		crank_o |->
			state_o == ess_pkg::S_CRANK || $past(state_o) == ess_pkg::S_CRANK;
	endproperty
	a_crank_out: assert property (p_crank_out) else $error("stray crank");
	property p_rest_entry;
		$changed(state_o) && state_o == ess_pkg::S_REST
			|-> $past(state_o) inside {ess_pkg::S_CRANK, ess_pkg::S_FALSE};
	endproperty
	a_rest_entry: assert property (p_rest_entry) else $error("rest entry");
	property p_run_entry;
		$changed(state_o) && state_o == ess_pkg::S_RUN |-> $past(state_o)
			inside {ess_pkg::S_FALSE, ess_pkg::S_WARM, ess_pkg::S_ASTOP};
	endproperty
	a_run_entry: assert property (p_run_entry) else $error("run entry");
	property p_manual;
		!auto_mode_o && !$past(auto_mode_o) |-> !(state_o inside
			{ess_pkg::S_ASTART, ess_pkg::S_WARM, ess_pkg::S_ASTOP, ess_pkg::S_COOL});
	endproperty
	a_manual: assert property (p_manual) else $error("auto state");
	property p_pre_states;
		prestart_o |-> state_o inside {ess_pkg::S_PRE1, ess_pkg::S_PRE2,
			ess_pkg::S_CRANK, ess_pkg::S_REST};
	endproperty
	a_pre_states: assert property (p_pre_states)
		else $error("stray prestart");
endmodule : ess_seq_checker
bind ess_sequencer ess_seq_checker ess_seq_checker_inst (.core_clk_i,
	.rstn_i, .engine_not_ready_i, .state_o, .prestart_o, .ecu_enable_o,
	.alarm_mask_o, .crank_o, .backlight_en_o, .heater_en_o, .can_en_o,
	.auto_mode_o);
`default_nettype wire

// File: tb/ess_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module ess_engine_model (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic crank_i,
	input wire logic stop_i,
	input wire logic [1:0] fail_starts_i,
	output logic started_o,
	output logic above_cutout_o,
	output logic zero_freq_o
);
	logic [1:0] fails_reg, crank_cnt_reg;
	logic [2:0] rpm_reg;
	// A crank shorter than four cycles never fires, and the first
	// fail_starts_i attempts fail on purpose so that crank rest is reached.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fails_reg <= 2'h0;
			crank_cnt_reg <= 2'h0;
			started_o <= 1'b0;
			rpm_reg <= 3'h0;
		end else begin
			crank_cnt_reg <= crank_i ?
				crank_cnt_reg + {1'b0, crank_cnt_reg != 2'h3} : 2'h0;
			if (stop_i)
				started_o <= 1'b0;
			else if (crank_i && crank_cnt_reg == 2'h3 && fails_reg >= fail_starts_i)
				started_o <= 1'b1;
			if (!crank_i && crank_cnt_reg != 2'h0 && !started_o && fails_reg != 2'h3)
				fails_reg <= fails_reg + 2'h1;
			rpm_reg <= started_o ? 3'h7 : rpm_reg - {2'h0, rpm_reg != 3'h0};
		end
	end
	// Speed decays over several cycles, so spindown must really wait.
	assign above_cutout_o = rpm_reg > 3'h3;
	assign zero_freq_o = rpm_reg == 3'h0;
endmodule : ess_engine_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, key_start, key_stop, key_any;
	logic a_start, a_stop, not_ready, safe, fault, link_ok, started, above;
	logic zero_freq, prestart, ecu_en, sender_en, alarm_mask, crank, stop_sol;
	logic backlight, heater, can_en, spd_valid, auto_mode;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, seen;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp, fail_starts;
	logic [15:0] spd;
	logic [4:0] state;
	int miscompares, num_checks;

	ess_sequencer #(.TICK_CYCLES(10)) ess_sequencer_inst (.core_clk_i(clk),
		.rstn_i(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .key_start_i(key_start), .key_stop_i(key_stop),
		.key_any_i(key_any), .auto_start_cond_i(a_start),
		.auto_stop_cond_i(a_stop), .engine_not_ready_i(not_ready),
		.safe_to_start_i(safe), .fault_i(fault), .link_ok_i(link_ok),
		.engine_started_i(started), .above_cutout_i(above),
		.zero_freq_i(zero_freq), .prestart_o(prestart), .ecu_enable_o(ecu_en),
		.sender_enable_o(sender_en), .alarm_mask_o(alarm_mask),
		.crank_o(crank), .stop_solenoid_o(stop_sol),
		.backlight_en_o(backlight), .heater_en_o(heater), .can_en_o(can_en),
		.speed_cmd_valid_o(spd_valid), .speed_cmd_o(spd),
		.auto_mode_o(auto_mode), .state_o(state));
	ess_engine_model ess_engine_model_inst (.core_clk_i(clk), .rstn_i(rstn),
		.crank_i(crank), .stop_i(stop_sol), .fail_starts_i(fail_starts),
		.started_o(started), .above_cutout_o(above), .zero_freq_o(zero_freq));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge clk) if (rstn) seen[state] = 1'b1;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Readies are sampled at the falling edge, where registered outputs
	// are settled, and acted on at the following rising edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hit, w_hit, b_hit;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			resp = bresp;
			@(posedge clk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end while (!b_hit);
		bready <= 1'b0;
	endtask : wr
	task automatic rd_reg(input logic [7:0] a);
		logic ar_hit, r_hit;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ar_hit = arvalid && arready;
			r_hit = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge clk);
			if (ar_hit) arvalid <= 1'b0;
		end while (!r_hit);
		rready <= 1'b0;
	endtask : rd_reg
	// State is looked at on falling edges only, and the task hands back
	// control on a rising edge so that callers drive inputs there.
	task automatic wait_st(input logic [4:0] s, input int n);
		@(negedge clk);
		while (state !== s && n > 0) begin
			@(negedge clk);
			n--;
		end
		chk(32'(state), 32'(s));
		@(posedge clk);
	endtask : wait_st
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{key_start, key_stop, key_any, a_start, a_stop, not_ready, fault} = '0;
		{awaddr, araddr, wdata, seen} = '0;
		{safe, link_ok, wstrb, fail_starts} = {2'b11, 4'hF, 2'h1};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		wait_st(ess_pkg::S_STAB, 0);
		chk(32'(ecu_en), 32'h1);
		rd_reg(ess_pkg::A_CTRL);
		chk(rd, 32'h0);
		rd_reg(ess_pkg::A_DUR0);
		chk(rd, 32'h5);
		rd_reg(8'h78);
		chk(32'(resp), 32'h2);
		// Stopped gets three seconds so that standby is reached before the start.
		for (int i = 0; i < ess_pkg::NUM_T; i++)
			wr(ess_pkg::A_DUR0 + 8'(4 * i), i == ess_pkg::T_STOPPED ? 32'h3 :
				i == ess_pkg::T_WARM ? 32'h0 :
				i == ess_pkg::T_CRANK ? 32'h0300_0001 : 32'h1);
		wait_st(ess_pkg::S_STOPPED, 300);
		wait_st(ess_pkg::S_STANDBY, 100);
		@(negedge clk);
		chk(32'({backlight, heater, can_en}), 32'h0);
		@(posedge clk);
		not_ready <= 1'b1;
		key_start <= 1'b1;
		repeat (6) @(posedge clk);
		key_start <= 1'b0;
		wait_st(ess_pkg::S_WAIT, 50);
		repeat (20) @(posedge clk);
		wait_st(ess_pkg::S_WAIT, 0);
		not_ready <= 1'b0;
		wait_st(ess_pkg::S_PRE1, 50);
		@(negedge clk);
		chk(32'(prestart), 32'h1);
		@(posedge clk);
		wait_st(ess_pkg::S_REST, 200);
		wait_st(ess_pkg::S_RUN, 300);
		repeat (30) @(posedge clk);
		wait_st(ess_pkg::S_RUN, 0);
		seen = '0;
		wr(ess_pkg::A_CTRL, 32'h4);
		wait_st(ess_pkg::S_STOPPED, 600);
		chk(32'({seen[ess_pkg::S_SPIN], seen[ess_pkg::S_COOL]}), 32'h2);
		wr(ess_pkg::A_CTRL, 32'h1);
		chk(32'(auto_mode), 32'h1);
		a_start <= 1'b1;
		repeat (3) @(posedge clk);
		a_start <= 1'b0;
		seen = '0;
		repeat (40) @(posedge clk);
		chk(32'(seen[ess_pkg::S_PRE1]), 32'h0);
		a_start <= 1'b1;
		wait_st(ess_pkg::S_RUN, 600);
		chk(32'(seen[ess_pkg::S_WARM]), 32'h0);
		a_start <= 1'b0;
		a_stop <= 1'b1;
		repeat (4) @(posedge clk);
		a_stop <= 1'b0;
		repeat (20) @(posedge clk);
		wait_st(ess_pkg::S_RUN, 0);
		a_stop <= 1'b1;
		wait_st(ess_pkg::S_COOL, 100);
		wait_st(ess_pkg::S_STOPPED, 600);
		a_stop <= 1'b0;
		chk(32'(auto_mode), 32'h0);
		wr(ess_pkg::A_SPEED, 32'h0300_0100);
		wr(ess_pkg::A_RUNCMD, 32'h0400_0200);
		wr(ess_pkg::A_DUR0 + 8'(4 * ess_pkg::T_WARM), 32'h1);
		// A long cooldown, so that only the held key can cut it short.
		wr(ess_pkg::A_DUR0 + 8'(4 * ess_pkg::T_COOL), 32'h5);
		wr(ess_pkg::A_CTRL, 32'h11);
		a_start <= 1'b1;
		wait_st(ess_pkg::S_CRANK, 600);
		chk(32'(prestart), 32'h1);
		wait_st(ess_pkg::S_WARM, 50);
		chk(32'(spd), 32'h200);
		chk(32'(prestart), 32'h0);
		wait_st(ess_pkg::S_RUN, 100);
		chk(32'(spd), 32'h400);
		a_start <= 1'b0;
		key_stop <= 1'b1;
		wait_st(ess_pkg::S_COOL, 10);
		chk(32'(spd), 32'h300);
		wait_st(ess_pkg::S_SOLENOID, 30);
		key_stop <= 1'b0;
		wait_st(ess_pkg::S_STOPPED, 600);
		chk(32'(auto_mode), 32'h0);
		summarize();
	end
endmodule : testbench
`default_nettype wire
